/* rtl/hts_host.sv */
// Host controller that reads the single-wire humidity and temperature sensor.
// Assumes an external pull-up on the data wire and a 40 MHz system clock.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - No start request is sent during the first second after reset.
// - The wire idles high through the pull-up whenever nobody drives it.
// - A start holds the wire low for at least 18 ms, then releases it and awaits a reply.
// - The sum field must equal the low byte of the four data fields added, else it fails.
// - A wire that stays high when the reply is due is reported as a missing sensor.
// - Successive readings start at least one second apart.
module hts_host import hts_pkg::*; #(
  parameter int unsigned POWERUP_CYC = `HTS_POWERUP_US * `HTS_CLK_MHZ,
  parameter int unsigned INTERVAL_CYC = `HTS_INTERVAL_US * `HTS_CLK_MHZ,
  parameter int unsigned START_CYC = `HTS_START_LOW_US * `HTS_CLK_MHZ,
  parameter int unsigned BUF_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  output logic start_ready_o,
  output logic busy_o,
  input wire logic line_i,
  output logic line_o,
  output logic line_oe_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [`HTS_FIELD_BITS-1:0] rd_hum_int_o,
  output logic [`HTS_FIELD_BITS-1:0] rd_hum_dec_o,
  output logic [`HTS_FIELD_BITS-1:0] rd_tmp_int_o,
  output logic [`HTS_FIELD_BITS-1:0] rd_tmp_dec_o,
  output logic [`HTS_ERR_W-1:0] rd_err_o
);

  // --------------------------------------------------------------------------
  // Timing counts
  // --------------------------------------------------------------------------
  localparam int unsigned EDGE_TO_CYC = `HTS_EDGE_TO_US * `HTS_CLK_MHZ;
  localparam int unsigned THRESH_CYC = `HTS_BIT_THRESH_US * `HTS_CLK_MHZ;
  localparam int unsigned RES_W = `HTS_DATA_BITS + `HTS_ERR_W;
  localparam logic [`HTS_TMR_W-1:0] TO_LIM = `HTS_TMR_W'(EDGE_TO_CYC - 1);
  localparam logic [`HTS_TMR_W-1:0] START_LIM = `HTS_TMR_W'(START_CYC - 1);
  localparam logic [`HTS_TMR_W-1:0] THRESH = `HTS_TMR_W'(THRESH_CYC);
  localparam logic [`HTS_TMR_W-1:0] POWERUP = `HTS_TMR_W'(POWERUP_CYC);
  localparam logic [`HTS_TMR_W-1:0] INTERVAL = `HTS_TMR_W'(INTERVAL_CYC);
  localparam logic [`HTS_NBIT_W-1:0] LAST_BIT = `HTS_NBIT_W'(`HTS_FRAME_BITS - 1);

  // --------------------------------------------------------------------------
  // State and helpers
  // --------------------------------------------------------------------------
  hts_host_st_t q;
  hts_host_st_t d;
  logic timeout;
  logic push_valid;
  logic push_ready;
  logic [RES_W-1:0] push_data;
  logic [RES_W-1:0] pop_data;
  logic [`HTS_FIELD_BITS-1:0] sum;
  logic [`HTS_DATA_BITS-1:0] frame_data;

  assign timeout = (q.tmr >= TO_LIM);
  assign frame_data = q.sh[`HTS_FIELD_BITS +: `HTS_DATA_BITS];
  assign sum = frame_data[`HTS_LANE3 +: `HTS_FIELD_BITS]
    + frame_data[`HTS_LANE2 +: `HTS_FIELD_BITS]
    + frame_data[`HTS_LANE1 +: `HTS_FIELD_BITS]
    + frame_data[`HTS_LANE0 +: `HTS_FIELD_BITS];

  // --------------------------------------------------------------------------
  // Pin and handshake outputs
  // --------------------------------------------------------------------------
  assign line_o = 1'b0;
  assign line_oe_o = (q.st == HTS_START_LOW);
  assign busy_o = (q.st != HTS_IDLE);
  assign start_ready_o = (q.st == HTS_IDLE) && (q.gap == '0) && push_ready;
  assign push_valid = (q.st == HTS_DONE);
  assign push_data = (q.err == `HTS_ERR_NONE) ? {q.err, frame_data}
    : {q.err, `HTS_DATA_BITS'(0)};

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = line_i;
    d.s2 = q.s1;
    d.tmr = `HTS_TMR_W'(q.tmr + 1'b1);
    if (q.gap != '0) begin
      d.gap = `HTS_TMR_W'(q.gap - 1'b1);
    end
    unique case (q.st)
      HTS_IDLE: begin
        if (start_i && start_ready_o) begin
          d.st = HTS_START_LOW;
          d.tmr = '0;
          d.gap = INTERVAL;
          d.nbit = '0;
          d.sh = '0;
          d.err = `HTS_ERR_NONE;
        end
      end
      HTS_START_LOW: begin
        if (q.tmr >= START_LIM) begin
          d.st = HTS_WAIT_REL;
          d.tmr = '0;
        end
      end
      HTS_WAIT_REL: begin
        if (q.s2) begin
          d.st = HTS_WAIT_RESP;
          d.tmr = '0;
        end else if (timeout) begin
          d.st = HTS_DONE;
          d.err = `HTS_ERR_TIMEOUT;
        end
      end
      HTS_WAIT_RESP: begin
        if (!q.s2) begin
          d.st = HTS_RESP_LOW;
          d.tmr = '0;
        end else if (timeout) begin
          d.st = HTS_DONE;
          d.err = `HTS_ERR_NORESP;
        end
      end
      HTS_RESP_LOW: begin
        if (q.s2) begin
          d.st = HTS_RESP_HIGH;
          d.tmr = '0;
        end else if (timeout) begin
          d.st = HTS_DONE;
          d.err = `HTS_ERR_TIMEOUT;
        end
      end
      HTS_RESP_HIGH: begin
        if (!q.s2) begin
          d.st = HTS_BIT_LOW;
          d.tmr = '0;
        end else if (timeout) begin
          d.st = HTS_DONE;
          d.err = `HTS_ERR_TIMEOUT;
        end
      end
      HTS_BIT_LOW: begin
        if (q.s2) begin
          d.st = HTS_BIT_HIGH;
          d.tmr = '0;
        end else if (timeout) begin
          d.st = HTS_DONE;
          d.err = `HTS_ERR_TIMEOUT;
        end
      end
      HTS_BIT_HIGH: begin
        if (!q.s2) begin
          d.sh = {q.sh[`HTS_FRAME_BITS-2:0], (q.tmr >= THRESH)};
          d.nbit = `HTS_NBIT_W'(q.nbit + 1'b1);
          d.tmr = '0;
          d.st = (q.nbit == LAST_BIT) ? HTS_TAIL : HTS_BIT_LOW;
        end else if (timeout) begin
          d.st = HTS_DONE;
          d.err = `HTS_ERR_TIMEOUT;
        end
      end
      HTS_TAIL: begin
        if (q.s2) begin
          d.st = HTS_DONE;
          if (sum != q.sh[`HTS_LANE0 +: `HTS_FIELD_BITS]) begin
            d.err = `HTS_ERR_CKSUM;
          end
        end else if (timeout) begin
          d.st = HTS_DONE;
          d.err = `HTS_ERR_TIMEOUT;
        end
      end
      HTS_DONE: begin
        if (push_ready) begin
          d.st = HTS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q.st <= HTS_IDLE;
      q.tmr <= '0;
      q.gap <= POWERUP;
      q.sh <= '0;
      q.nbit <= '0;
      q.err <= `HTS_ERR_NONE;
      q.s1 <= 1'b1;
      q.s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Result buffer
  // --------------------------------------------------------------------------
  hts_buf #(
    .W(RES_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_data),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(pop_data)
  );

  // Fields leave in frame order, first field in the top byte.
  assign rd_err_o = pop_data[RES_W-1:`HTS_DATA_BITS];
  assign rd_hum_int_o = pop_data[`HTS_LANE3 +: `HTS_FIELD_BITS];
  assign rd_hum_dec_o = pop_data[`HTS_LANE2 +: `HTS_FIELD_BITS];
  assign rd_tmp_int_o = pop_data[`HTS_LANE1 +: `HTS_FIELD_BITS];
  assign rd_tmp_dec_o = pop_data[`HTS_LANE0 +: `HTS_FIELD_BITS];

endmodule

`default_nettype wire

/* shared/hts_map.svh */
// Named constants for the single-wire humidity and temperature sensor host.
// Assumes it is included by its bare name from the package and the checker.
`ifndef HTS_MAP_SVH
`define HTS_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define HTS_CLK_MHZ 40
`define HTS_POWERUP_US 1000000
`define HTS_INTERVAL_US 1000000
`define HTS_START_LOW_US 18000
`define HTS_EDGE_TO_US 100
`define HTS_BIT_THRESH_US 48

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define HTS_FRAME_BITS 40
`define HTS_FIELD_BITS 8
`define HTS_DATA_BITS 32
`define HTS_NBIT_W 6
`define HTS_TMR_W 32
`define HTS_LANE3 24
`define HTS_LANE2 16
`define HTS_LANE1 8
`define HTS_LANE0 0

// ----------------------------------------------------------------------------
// Result codes
// ----------------------------------------------------------------------------
`define HTS_ERR_W 2
`define HTS_ERR_NONE 2'h0
`define HTS_ERR_NORESP 2'h1
`define HTS_ERR_TIMEOUT 2'h2
`define HTS_ERR_CKSUM 2'h3

`endif

/* shared/hts_pkg.sv */
// Types for the single-wire humidity and temperature sensor host.
// Assumes hts_map.svh is on the include path.
`default_nettype none
`include "hts_map.svh"

package hts_pkg;

  // --------------------------------------------------------------------------
  // Host sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    HTS_IDLE      = 4'h0,
    HTS_START_LOW = 4'h1,
    HTS_WAIT_REL  = 4'h2,
    HTS_WAIT_RESP = 4'h3,
    HTS_RESP_LOW  = 4'h4,
    HTS_RESP_HIGH = 4'h5,
    HTS_BIT_LOW   = 4'h6,
    HTS_BIT_HIGH  = 4'h7,
    HTS_TAIL      = 4'h8,
    HTS_DONE      = 4'h9
  } hts_state_t;

  // --------------------------------------------------------------------------
  // Host state record
  // --------------------------------------------------------------------------
  typedef struct packed {
    hts_state_t st;
    logic [`HTS_TMR_W-1:0] tmr;
    logic [`HTS_TMR_W-1:0] gap;
    logic [`HTS_FRAME_BITS-1:0] sh;
    logic [`HTS_NBIT_W-1:0] nbit;
    logic [`HTS_ERR_W-1:0] err;
    logic s1;
    logic s2;
  } hts_host_st_t;

endpackage

`default_nettype wire

/* rtl/hts_buf.sv */
// Small result buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module hts_buf #(
  parameter int unsigned W = 34,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int unsigned AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } hts_buf_st_t;

  hts_buf_st_t q;
  hts_buf_st_t d;
  logic push;
  logic pop;

  // --------------------------------------------------------------------------
  // Handshakes
  // --------------------------------------------------------------------------
  assign in_ready_o = (q.cnt != FULL);
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = (q.wp == LAST) ? '0 : AW'(q.wp + 1'b1);
    end
    if (pop) begin
      d.rp = (q.rp == LAST) ? '0 : AW'(q.rp + 1'b1);
    end
    if (push && !pop) begin
      d.cnt = (AW + 1)'(q.cnt + 1'b1);
    end else if (pop && !push) begin
      d.cnt = (AW + 1)'(q.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

/* verification/hts_host_properties.sv */
// Checker on the ports of the single-wire sensor host.
// Assumes the bind at the foot attaches it to every host instance.
`timescale 1ns/1ps
`default_nettype none
`include "hts_map.svh"
module hts_host_properties #(
  parameter int unsigned POWERUP_CYC = 100,
  parameter int unsigned INTERVAL_CYC = 200,
  parameter int unsigned START_CYC = 50
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic start_ready_o,
  input wire logic busy_o,
  input wire logic line_o,
  input wire logic line_oe_o,
  input wire logic rd_valid_o,
  input wire logic rd_ready_i,
  input wire logic [`HTS_FIELD_BITS-1:0] rd_hum_int_o,
  input wire logic [`HTS_FIELD_BITS-1:0] rd_hum_dec_o,
  input wire logic [`HTS_FIELD_BITS-1:0] rd_tmp_int_o,
  input wire logic [`HTS_FIELD_BITS-1:0] rd_tmp_dec_o,
  input wire logic [`HTS_ERR_W-1:0] rd_err_o
);
  logic [31:0] up_q, oe_q, gap_q, data_w;
  assign data_w = {rd_hum_int_o, rd_hum_dec_o, rd_tmp_int_o, rd_tmp_dec_o};
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      up_q <= 32'h0;
      oe_q <= 32'h0;
      gap_q <= 32'hffffffff;
    end else begin
      up_q <= (up_q != 32'hffffffff) ? up_q + 32'h1 : up_q;
      oe_q <= line_oe_o ? oe_q + 32'h1 : 32'h0;
      gap_q <= (start_i && start_ready_o) ? 32'h0 : gap_q + {31'h0, gap_q != 32'hffffffff};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_acc;
    start_i && start_ready_o;
  endsequence
  sequence s_drv;
    line_oe_o && busy_o && !start_ready_o;
  endsequence
  a_power_wait: assert property (line_oe_o |-> up_q >= POWERUP_CYC)
    else $error("early start");
  a_pull_only: assert property (line_oe_o |-> !line_o)
    else $error("drove high");
  a_idle_free: assert property (!busy_o |-> !line_oe_o)
    else $error("idle drive");
  a_accept_drive: assert property (s_acc |=> s_drv)
    else $error("start not driven");
  a_start_len: assert property ($fell(line_oe_o) |-> oe_q == START_CYC)
    else $error("start length");
  a_start_gap: assert property (s_acc |-> gap_q >= INTERVAL_CYC - 1)
    else $error("starts too close");
  a_ready_idle: assert property (start_ready_o |-> !busy_o)
    else $error("ready while busy");
  a_result_hold: assert property (rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(data_w))
    else $error("result changed");
  a_err_clean: assert property (rd_valid_o && rd_err_o != `HTS_ERR_NONE |-> data_w == 32'h0)
    else $error("error with data");
endmodule
bind hts_host hts_host_properties #(.POWERUP_CYC(POWERUP_CYC), .INTERVAL_CYC(INTERVAL_CYC),
  .START_CYC(START_CYC)) chk_u (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
  .start_ready_o(start_ready_o), .busy_o(busy_o), .line_o(line_o), .line_oe_o(line_oe_o),
  .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_hum_int_o(rd_hum_int_o),
  .rd_hum_dec_o(rd_hum_dec_o), .rd_tmp_int_o(rd_tmp_int_o), .rd_tmp_dec_o(rd_tmp_dec_o),
  .rd_err_o(rd_err_o));
`default_nettype wire

/* verification/hts_sensor_model.sv */
// Behavioural sensor on the far end of the single data wire.
// Assumes the bench resolves the wire from all pull-downs and a pull-up.
`timescale 1ns/1ps
`default_nettype none
module hts_sensor_model #(
  parameter int RESP_CYC = 3200,
  parameter int TURN_CYC = 800,
  parameter int BIT_LOW_CYC = 2000,
  parameter int ZERO_HI_CYC = 1040,
  parameter int ONE_HI_CYC = 2800
) (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic silent_i,
  input wire logic stall_i,
  input wire logic bad_sum_i,
  input wire logic [31:0] data_i,
  output logic low_o
);
  logic [39:0] frame_q;
  task automatic phase(input logic pull, input int n);
    low_o <= pull;
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    low_o = 1'b0;
    forever begin
      @(negedge line_i);
      @(posedge line_i);
      frame_q = {data_i, data_i[31:24] + data_i[23:16] + data_i[15:8] + data_i[7:0]
        + {7'h0, bad_sum_i}};
      if (!silent_i) begin
        @(posedge clk_i);
        phase(1'b0, TURN_CYC);
        phase(1'b1, RESP_CYC);
        phase(1'b0, RESP_CYC);
        if (!stall_i) begin
          for (int i = 39; i >= 0; i--) begin
            phase(1'b1, BIT_LOW_CYC);
            phase(1'b0, frame_q[i] ? ONE_HI_CYC : ZERO_HI_CYC);
          end
          phase(1'b1, BIT_LOW_CYC);
        end
        low_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/hts_host_test.sv */
// Self-checking bench for the single-wire sensor host.
// Assumes the sensor model and the checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define HT_CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module hts_host_test;
  localparam int unsigned PU = 100, IV = 6000, SC = 50, LIM = 40000;
  logic clk_i = 0, rstn_i = 0, start_i = 0, rd_ready_i = 0;
  logic silent = 0, stall = 0, bad_sum = 0, sens_low, line_w;
  logic [31:0] data = 32'h0;
  logic start_ready_o, busy_o, line_o, line_oe_o, rd_valid_o;
  logic [7:0] hi, hd, ti, td;
  logic [1:0] rd_err_o;
  int fails = 0, compares = 0;
  always #12.5 clk_i = ~clk_i;
  assign line_w = !((line_oe_o && !line_o) || sens_low);
  hts_host #(.POWERUP_CYC(PU), .INTERVAL_CYC(IV), .START_CYC(SC), .BUF_DEPTH(2)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .start_ready_o(start_ready_o),
    .busy_o(busy_o), .line_i(line_w), .line_o(line_o), .line_oe_o(line_oe_o),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .rd_hum_int_o(hi), .rd_hum_dec_o(hd),
    .rd_tmp_int_o(ti), .rd_tmp_dec_o(td), .rd_err_o(rd_err_o));
  hts_sensor_model #(.BIT_LOW_CYC(100), .ZERO_HI_CYC(200)) sens_u (.clk_i(clk_i),
    .line_i(line_w), .silent_i(silent), .stall_i(stall), .bad_sum_i(bad_sum),
    .data_i(data), .low_o(sens_low));
  task automatic tick();
    @(posedge clk_i);
    #2;
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (n < LIM && (sel == 0 ? start_ready_o : sel == 1 ? rd_valid_o : !busy_o) !== 1'b1) begin
      tick();
      n++;
    end
    if (n >= LIM) begin
      `HT_CHK(n, 0)
      stop_test();
    end
  endtask
  task automatic do_start();
    int n;
    wait_for(0);
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    `HT_CHK({line_oe_o, busy_o, start_ready_o}, 3'b110)
    n = 0;
    while (line_oe_o === 1'b1 && n < LIM) begin
      tick();
      n++;
    end
    `HT_CHK(n, SC)
  endtask
  task automatic pop_check(input logic [1:0] e, input logic [31:0] d);
    wait_for(1);
    `HT_CHK(rd_err_o, e)
    `HT_CHK({hi, hd, ti, td}, d)
    rd_ready_i = 1'b1;
    tick();
    rd_ready_i = 1'b0;
    tick();
  endtask
  task automatic t_power_up();
    `HT_CHK({start_ready_o, busy_o, line_oe_o, rd_valid_o, line_w}, 5'b00001)
    repeat (PU / 2) tick();
    `HT_CHK({start_ready_o, line_w}, 2'b01)
    wait_for(0);
    $display("t_power_up done");
  endtask
  task automatic t_held_results();
    data = 32'h01000200;
    do_start();
    wait_for(2);
    data = 32'h80010040;
    bad_sum = 1'b1;
    do_start();
    wait_for(2);
    repeat (SC) tick();
    `HT_CHK({start_ready_o, rd_valid_o}, 2'b01)
    pop_check(2'h0, 32'h01000200);
    pop_check(2'h3, 32'h0);
    `HT_CHK(rd_valid_o, 1'b0)
    bad_sum = 1'b0;
    $display("t_held_results done");
  endtask
  task automatic t_faults();
    silent = 1'b1;
    do_start();
    pop_check(2'h1, 32'h0);
    `HT_CHK({start_ready_o, busy_o, rd_valid_o}, 3'b000)
    silent = 1'b0;
    stall = 1'b1;
    do_start();
    pop_check(2'h2, 32'h0);
    stall = 1'b0;
    $display("t_faults done");
  endtask
  initial begin
    repeat (16) tick();
    rstn_i = 1'b1;
    t_power_up();
    t_held_results();
    t_faults();
    stop_test();
  end
endmodule
`default_nettype wire
